// ===== core/phy_mac_transmit_input.sv
// mac-facing transmit input: samples nibbles or dibits, hands nibbles on
`timescale 1ns/1ns
module phy_mac_transmit_input (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic txclk_i,
   input wire logic ref_clk_i,
   input wire logic [3:0] txd_i,
   input wire logic txen_i,
   input wire logic reduced_interface_select_strap_i,
   output logic [3:0] tx_data_o,
   output logic tx_end_o,
   output logic tx_valid_o,
   input wire logic tx_ready_i,
   output logic rmii_mode_o,
   output logic overflow_o
);
   // ----------------------------------------------------------------------
   // pin synchronisers, three stages each
   // ----------------------------------------------------------------------
   logic [2:0] txclk_s_r;
   logic [2:0] refclk_s_r;
   logic [2:0] txen_s_r;
   logic [2:0] strap_s_r;
   logic [3:0] txd_s1_r;
   logic [3:0] txd_s2_r;
   logic [3:0] txd_s3_r;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         txclk_s_r <= '0;
         refclk_s_r <= '0;
         txen_s_r <= '0;
         strap_s_r <= '0;
         txd_s1_r <= phy_tx_pkg::NIBBLE_RST;
         txd_s2_r <= phy_tx_pkg::NIBBLE_RST;
         txd_s3_r <= phy_tx_pkg::NIBBLE_RST;
      end else begin
         txclk_s_r <= {txclk_s_r[1:0], txclk_i};
         refclk_s_r <= {refclk_s_r[1:0], ref_clk_i};
         txen_s_r <= {txen_s_r[1:0], txen_i};
         strap_s_r <= {strap_s_r[1:0], reduced_interface_select_strap_i};
         txd_s1_r <= txd_i;
         txd_s2_r <= txd_s1_r;
         txd_s3_r <= txd_s2_r;
      end
   end

   // ----------------------------------------------------------------------
   // filtered levels: a change counts once stages two and three agree
   // ----------------------------------------------------------------------
   logic txclk_lvl_r;
   logic refclk_lvl_r;
   logic txen_lvl_r;
   logic [3:0] txd_lvl_r;
   logic mii_rise;
   logic ref_rise;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         txclk_lvl_r <= 1'h0;
         refclk_lvl_r <= 1'h0;
         txen_lvl_r <= 1'h0;
         txd_lvl_r <= phy_tx_pkg::NIBBLE_RST;
      end else begin
         if (txclk_s_r[1] == txclk_s_r[2]) begin
            txclk_lvl_r <= txclk_s_r[2];
         end
         if (refclk_s_r[1] == refclk_s_r[2]) begin
            refclk_lvl_r <= refclk_s_r[2];
         end
         if (txen_s_r[1] == txen_s_r[2]) begin
            txen_lvl_r <= txen_s_r[2];
         end
         if (txd_s2_r == txd_s3_r) begin
            txd_lvl_r <= txd_s3_r;
         end
      end
   end

   // the levels held before this cycle's update are the pre-edge values,
   // so data that the mac changes right at the edge is not picked up
   assign mii_rise = txclk_s_r[1] && txclk_s_r[2] && !txclk_lvl_r;
   assign ref_rise = refclk_s_r[1] && refclk_s_r[2] && !refclk_lvl_r;

   // ----------------------------------------------------------------------
   // mode strap, caught once after each reset release
   // ----------------------------------------------------------------------
   logic strap_done_r;
   logic mode_rmii_r;
   logic [2:0] strap_fill_r;

   // the stages hold reset zeros at first: the strap is trusted only once
   // three edges have pushed the pin itself through all of them
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         strap_fill_r <= '0;
      end else begin
         strap_fill_r <= {strap_fill_r[1:0], 1'b1};
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         strap_done_r <= 1'h0;
         mode_rmii_r <= phy_tx_pkg::MODE_RST;
      end else if (!strap_done_r && strap_fill_r[2]
         && strap_s_r[1] == strap_s_r[2]) begin
         strap_done_r <= 1'h1;
         mode_rmii_r <= (strap_s_r[2] == phy_tx_pkg::STRAP_RMII);
      end
   end

   assign rmii_mode_o = mode_rmii_r;

   // ----------------------------------------------------------------------
   // frame control
   // ----------------------------------------------------------------------
   phy_tx_pkg::tx_state_t state_r;
   phy_tx_pkg::tx_state_t state_nxt;
   logic sel_rise;
   logic take;
   logic half_r;
   logic [1:0] half_data_r;
   logic wr_valid;
   logic [phy_tx_pkg::FIFO_W-1:0] wr_data;
   logic fifo_ready;
   logic overflow_r;

   // the mode picks which clock's edge samples the bus
   assign sel_rise = strap_done_r
      && (mode_rmii_r ? ref_rise : mii_rise);
   // nothing is taken while the enable is low
   assign take = sel_rise && txen_lvl_r
      && (state_r != phy_tx_pkg::ST_CLOSE);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         phy_tx_pkg::ST_IDLE: begin
            if (take) begin
               state_nxt = phy_tx_pkg::ST_FRAME;
            end
         end
         phy_tx_pkg::ST_FRAME: begin
            if (sel_rise && !txen_lvl_r) begin
               state_nxt = phy_tx_pkg::ST_CLOSE;
            end
         end
         phy_tx_pkg::ST_CLOSE: begin
            if (fifo_ready) begin
               state_nxt = phy_tx_pkg::ST_IDLE;
            end
         end
         default: begin
            state_nxt = phy_tx_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= phy_tx_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // first dibit of a pair is held; an odd dibit at frame end is dropped
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         half_r <= 1'h0;
         half_data_r <= phy_tx_pkg::DIBIT_RST;
      end else if (state_r == phy_tx_pkg::ST_CLOSE) begin
         half_r <= 1'h0;
      end else if (take && mode_rmii_r) begin
         half_r <= !half_r;
         if (!half_r) begin
            half_data_r <= txd_lvl_r[1:0];
         end
      end
   end

   always_comb begin
      wr_valid = 1'b0;
      wr_data = phy_tx_pkg::END_MARK;
      if (state_r == phy_tx_pkg::ST_CLOSE) begin
         wr_valid = 1'b1;
      end else if (take && mode_rmii_r) begin
         wr_valid = half_r;
         wr_data = {1'b0, txd_lvl_r[1:0], half_data_r};
      end else if (take) begin
         wr_valid = 1'b1;
         wr_data = {1'b0, txd_lvl_r};
      end
   end

   // a nibble that meets a full fifo is lost; the flag stays up until the
   // next frame begins, a loss in that same cycle keeping it set
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         overflow_r <= 1'h0;
      end else if (wr_valid && !fifo_ready
         && state_r != phy_tx_pkg::ST_CLOSE) begin
         overflow_r <= 1'h1;
      end else if (take && state_r == phy_tx_pkg::ST_IDLE) begin
         overflow_r <= 1'h0;
      end
   end

   assign overflow_o = overflow_r;

   // ----------------------------------------------------------------------
   // buffer toward the transmit path
   // ----------------------------------------------------------------------
   logic [phy_tx_pkg::FIFO_W-1:0] rd_data;

   tx_fifo #(
      .WIDTH(phy_tx_pkg::FIFO_W),
      .DEPTH(phy_tx_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(wr_valid),
      .in_ready_o(fifo_ready),
      .in_data_i(wr_data),
      .out_valid_o(tx_valid_o),
      .out_ready_i(tx_ready_i),
      .out_data_o(rd_data)
   );

   assign tx_data_o = rd_data[3:0];
   assign tx_end_o = rd_data[4];

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   sequence mii_edge_en;
      strap_done_r && !mode_rmii_r && mii_rise && txen_lvl_r
         && state_r != phy_tx_pkg::ST_CLOSE;
   endsequence

   sequence frame_fall;
      state_r == phy_tx_pkg::ST_FRAME && sel_rise && !txen_lvl_r;
   endsequence

   AST_MII_SAMPLE: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      mii_edge_en |-> wr_valid && wr_data == {1'b0, txd_lvl_r})
      else $error("mii edge with enable did not write the nibble");

   AST_MII_NIBBLE_PER_EDGE: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (state_r != phy_tx_pkg::ST_CLOSE && !mode_rmii_r && !mii_rise)
      |-> !wr_valid)
      else $error("mii write without a transmit clock edge");

   AST_RMII_NO_TXCLK: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (mode_rmii_r && !ref_rise && state_r != phy_tx_pkg::ST_CLOSE)
      |-> !wr_valid)
      else $error("reduced mode wrote without a reference edge");

   AST_RMII_PAIR: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (mode_rmii_r && take && !half_r) |-> !wr_valid ##1 half_r
         && half_data_r == $past(txd_lvl_r[1:0]))
      else $error("first dibit not held");

   AST_RMII_JOIN: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (mode_rmii_r && take && half_r) |-> wr_valid
         && wr_data == {1'b0, txd_lvl_r[1:0], half_data_r})
      else $error("dibit pair not joined into a nibble");

   AST_MODE_HOLD: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      strap_done_r |=> strap_done_r && $stable(mode_rmii_r))
      else $error("mode changed without a reset");

   AST_IDLE_IGNORE: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (state_r != phy_tx_pkg::ST_CLOSE && !txen_lvl_r) |-> !wr_valid)
      else $error("data taken while enable was low");

   // an odd dibit left at the fall is only dropped by the close cycle
   AST_FRAME_END: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      frame_fall |=> state_r == phy_tx_pkg::ST_CLOSE && wr_valid
         && wr_data == phy_tx_pkg::END_MARK ##1 !half_r)
      else $error("falling enable did not close the frame");
endmodule

// ===== core/phy_tx_pkg.sv
// constants and types shared by the mac transmit input block
// ----------------------------------------------------------------------
// Behaviour
// - Full-width mode takes data and enable on the transmit clock rise.
// - Full-width mode moves one 4-bit nibble per transfer at 25 MHz.
// - Reduced mode takes data and enable on the reference clock rise.
// - Reduced mode moves one 2-bit dibit per transfer at 50 MHz.
// - The mode strap is caught after each reset and held until the next.
// ----------------------------------------------------------------------
package phy_tx_pkg;
   localparam int NIBBLE_W = 4;
   localparam int DIBIT_W = 2;
   localparam int FIFO_DEPTH = 4;
   localparam int FIFO_W = NIBBLE_W + 1;
   localparam int MII_RATE_MHZ = 25;
   localparam int RMII_RATE_MHZ = 50;
   localparam int CLK_RATE_MHZ = 250;
   // strap level that selects the reduced interface
   localparam logic STRAP_RMII = 1'h1;
   localparam logic MODE_RST = 1'h0;
   localparam logic [NIBBLE_W-1:0] NIBBLE_RST = 4'h0;
   localparam logic [DIBIT_W-1:0] DIBIT_RST = 2'h0;
   localparam logic [FIFO_W-1:0] END_MARK = 5'h1_0;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_FRAME = 2'b01,
      ST_CLOSE = 2'b11
   } tx_state_t;
endpackage

// ===== core/tx_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ns
module tx_fifo #(
   parameter int WIDTH = phy_tx_pkg::FIFO_W,
   parameter int DEPTH = phy_tx_pkg::FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;

   assign in_ready_o = (count_r != DEPTH_C);
   assign out_valid_o = (count_r != '0);
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem_r[rd_ptr_r];

   // ----------------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_r[i] <= '0;
         end
      end else if (push) begin
         mem_r[wr_ptr_r] <= in_data_i;
      end
   end

   // ----------------------------------------------------------------------
   // pointers and fill level
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule

// ===== dv/mac_tx_model.sv
// mac side model: link clocks, enable and data of transmit frames
`timescale 1ns/1ns
module mac_tx_model (
   input wire logic clk_i,
   output logic txclk_o,
   output logic ref_clk_o,
   output logic [3:0] txd_o,
   output logic txen_o
);
   logic lclk = 1'b0;
   logic run = 1'b0;
   logic rmii = 1'b0;
   initial begin
      txd_o = 4'h0;
      txen_o = 1'b0;
   end
   // the unused clock rises while data changes, so a wrong pick shows
   assign txclk_o = rmii ? (run & ~lclk) : lclk;
   assign ref_clk_o = rmii ? lclk : (run & ~lclk);

   // one 48 ns link period of twelve system clocks; data moves only on
   // the falling link edge, so it is settled at every rising one
   task automatic beat(input logic en, input logic [3:0] d);
      txd_o <= d;
      txen_o <= en;
      repeat (6) @(posedge clk_i);
      lclk <= 1'b1;
      repeat (6) @(posedge clk_i);
      lclk <= 1'b0;
   endtask

   task automatic send(input logic mode, input logic [23:0] data,
      input int n);
      logic [3:0] nib;
      rmii <= mode;
      @(posedge clk_i);
      run <= 1'b1;
      for (int i = 0; i < n; i++) begin
         nib = data[4*i +: 4];
         if (mode) begin
            beat(1'b1, {~nib[1:0], nib[1:0]});
            beat(1'b1, {~nib[3:2], nib[3:2]});
         end else begin
            beat(1'b1, nib);
         end
      end
      // released bus shows the inverse, never the last value
      beat(1'b0, ~txd_o);
      run <= 1'b0;
   endtask
endmodule

// ===== dv/phy_mac_transmit_input_bench.sv
// self-checking bench for the mac transmit input block
`timescale 1ns/1ns
module phy_mac_transmit_input_bench;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic strap = 1'b0;
   logic tx_ready_i = 1'b0;
   logic txclk, ref_clk, txen;
   logic [3:0] txd, tx_data_o;
   logic tx_end_o, tx_valid_o, rmii_mode_o, overflow_o;
   logic [4:0] q[$];
   int miscompares = 0;
   int tests_run = 0;

   always #2 clk_i = ~clk_i;

   mac_tx_model mac (.clk_i(clk_i), .txclk_o(txclk), .ref_clk_o(ref_clk),
      .txd_o(txd), .txen_o(txen));

   phy_mac_transmit_input DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .txclk_i(txclk), .ref_clk_i(ref_clk), .txd_i(txd), .txen_i(txen),
      .reduced_interface_select_strap_i(strap), .tx_data_o(tx_data_o),
      .tx_end_o(tx_end_o), .tx_valid_o(tx_valid_o),
      .tx_ready_i(tx_ready_i), .rmii_mode_o(rmii_mode_o),
      .overflow_o(overflow_o));

   always @(posedge clk_i) begin
      if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
         q.push_back({tx_end_o, tx_data_o});
      end
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic check(input logic [4:0] seen, input logic [4:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic do_reset(input logic s);
      rst_n_i <= 1'b0;
      strap <= s;
      tx_ready_i <= 1'b0;
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      q.delete();
   endtask

   // waits for n data words plus the end marker, then compares all
   task automatic expect_frame(input logic [23:0] data, input int n);
      int k;
      k = 0;
      while (q.size() < n + 1 && k < 400) begin
         @(posedge clk_i);
         k++;
      end
      if (k >= 400) begin
         miscompares++;
         $display("[FAIL] %0t frame never completed", $time);
         report_and_stop();
      end
      repeat (20) @(posedge clk_i);
      check(5'(q.size()), 5'(n + 1));
      for (int i = 0; i < n; i++) begin
         check(q[i], {1'b0, data[4*i +: 4]});
      end
      check(q[n], phy_tx_pkg::END_MARK);
      q.delete();
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic test_full();
      do_reset(1'b0);
      check({4'h0, rmii_mode_o}, 5'h0_0);
      tx_ready_i <= 1'b1;
      mac.send(1'b0, 24'h00_9e71, 4);
      expect_frame(24'h00_9e71, 4);
      mac.send(1'b0, 24'h00_0005, 1);
      expect_frame(24'h00_0005, 1);
   endtask

   task automatic test_reduced();
      do_reset(1'b1);
      check({4'h0, rmii_mode_o}, 5'h0_1);
      strap <= 1'b0;
      tx_ready_i <= 1'b1;
      mac.send(1'b1, 24'h00_0b6d, 3);
      expect_frame(24'h00_0b6d, 3);
      check({4'h0, rmii_mode_o}, 5'h0_1);
   endtask

   // downstream stalls: four words kept, the rest dropped and flagged
   task automatic test_overflow();
      do_reset(1'b0);
      mac.send(1'b0, 24'h4c_28f3, 6);
      repeat (20) @(posedge clk_i);
      check({4'h0, overflow_o}, 5'h0_1);
      tx_ready_i <= 1'b1;
      expect_frame(24'h00_28f3, 4);
      mac.send(1'b0, 24'h00_000a, 1);
      check({4'h0, overflow_o}, 5'h0_0);
      expect_frame(24'h00_000a, 1);
   endtask

   initial begin
      test_full();
      test_reduced();
      test_overflow();
      report_and_stop();
   end
endmodule
